// >>> common/fpsd_pkg.sv
// fpsd_pkg: constants, enums and carriers of the sine/cosine/sinh decoder.
// assumes: fields follow the coprocessor general-op opcode and extension words.
package fpsd_pkg;
	localparam logic [3:0] OP_LINE   = 4'hf;
	localparam logic [2:0] CPID_RST  = 3'h1;
	localparam logic [2:0] GEN_TYPE  = 3'h0;
	localparam logic [3:0] SC_OPM    = 4'h6;
	localparam logic [6:0] SINH_OPM  = 7'h02;
	localparam logic [6:0] SIN_OPM   = 7'h0e;
	localparam logic [2:0] FMT_L     = 3'h0;
	localparam logic [2:0] FMT_S     = 3'h1;
	localparam logic [2:0] FMT_P     = 3'h3;
	localparam logic [2:0] FMT_W     = 3'h4;
	localparam logic [2:0] FMT_B     = 3'h6;
	localparam logic [2:0] FMT_BAD   = 3'h7;
	localparam logic [2:0] M_DREG    = 3'h0;
	localparam logic [2:0] M_AREG    = 3'h1;
	localparam logic [2:0] M_IND     = 3'h2;
	localparam logic [2:0] M_POST    = 3'h3;
	localparam logic [2:0] M_PRE     = 3'h4;
	localparam logic [2:0] M_D16     = 3'h5;
	localparam logic [2:0] M_IDX     = 3'h6;
	localparam logic [2:0] M_EXT     = 3'h7;
	localparam logic [2:0] R_ABSW    = 3'h0;
	localparam logic [2:0] R_ABSL    = 3'h1;
	localparam logic [2:0] R_PCD     = 3'h2;
	localparam logic [2:0] R_PCX     = 3'h3;
	localparam logic [2:0] R_IMM     = 3'h4;
	localparam int         ADDR_W    = 8;
	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_STAT  = 8'h04;
	localparam logic [7:0] REG_LAST  = 8'h08;
	typedef enum logic [1:0] {OP_NONE = 2'h0, OP_SINCOS = 2'h1,
		OP_SINH = 2'h3, OP_SIN = 2'h2} fpsd_op_t;
	typedef enum logic [3:0] {EA_NONE, EA_DREG, EA_IND, EA_POST, EA_PRE,
		EA_D16, EA_IDX, EA_ABSW, EA_ABSL, EA_PCD, EA_PCX, EA_IMM} fpsd_ea_t;
	typedef enum logic [2:0] {RS_CALC, RS_ZERO, RS_ONE, RS_NAN,
		RS_INF} fpsd_res_t;
	typedef struct packed {
		logic [15:0] opcode;
		logic [15:0] ext;
	} fpsd_issue_t;
	// source class and arithmetic side results for the issued operand
	typedef struct packed {
		logic zero;
		logic inf;
		logic signalling_nan;
		logic beyond_2pi;
		logic sin_underflow;
		logic overflow;
		logic underflow;
		logic inexact;
		logic dec_inexact;
	} fpsd_class_t;
	typedef struct packed {
		logic branch_unordered_flag;
		logic signalling_nan_flag;
		logic operand_error_flag;
		logic overflow_flag;
		logic underflow_flag;
		logic divide_zero_flag;
		logic inexact_result_flag;
		logic decimal_input_inexact_flag;
	} fpsd_exc_t;
	typedef struct packed {
		fpsd_op_t op;
		logic     illegal;
		logic     rm;
		logic [2:0] src_reg;
		logic [2:0] fmt;
		fpsd_ea_t ea;
		logic [2:0] ea_reg;
		logic [2:0] sin_dest;
		logic [2:0] cos_dest;
		logic     wr_sin;
		logic     wr_cos;
		logic     read_first;
	} fpsd_dec_t;
endpackage

// >>> core/fpsd_core.sv
// fpsd_core: decode and status of the sine/cosine, sine and sinh operations.
// assumes: issue words and operand class come from logic on mclk_in.
//
// Summary of operation
// - source bit zero register, one memory
// - register mode: specifier picks source register
// - memory mode: specifier decodes the data format
// - data register mode only for B/W/L/S
// - mode codes 010..110 use address register
// - mode 111 register field picks special mode
// - equal source and destination reuse one register
// - sincos writes sine and cosine destinations
// - condition codes follow the sine result
// - same destinations keep sine, drop cosine
// - overlapping source read before result write
// - reduce arguments beyond two pi first
// - zero gives signed zero, one; infinity NaN
// - operand error set only for infinite source
// - underflow from sine only, cosine one
// - clear unordered, overflow, divide; quotient kept
// - decimal inexact only for packed format
// - opcode line all ones, coprocessor id matches
// - sincos opmode 0110, cosine in bits 2..0
// - sinh writes its single destination
// - sinh special values and cleared flags
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module fpsd_core (
	// clock and reset
	input  wire logic                 mclk_in,
	input  wire logic                 resetn_in,
	// instruction issue
	input  wire logic                 issue_valid_in,
	input  wire fpsd_pkg::fpsd_issue_t issue_in,
	input  wire fpsd_pkg::fpsd_class_t class_in,
	// register port
	input  wire logic [fpsd_pkg::ADDR_W-1:0] addr_in,
	input  wire logic [31:0]          wdata_in,
	input  wire logic                 wr_in,
	input  wire logic                 rd_in,
	output logic      [31:0]          rdata_out,
	// decode results
	output logic                      dec_valid_out,
	output var fpsd_pkg::fpsd_dec_t   dec_out,
	output var fpsd_pkg::fpsd_res_t   sin_res_out,
	output var fpsd_pkg::fpsd_res_t   cos_res_out,
	output logic                      reduce_out,
	output logic                      cc_sine_out,
	output var fpsd_pkg::fpsd_exc_t   exc_out
);
	logic [2:0]          cpid;
	logic [7:0]          quot;
	fpsd_pkg::fpsd_dec_t next_dec;
	fpsd_pkg::fpsd_exc_t next_exc;
	fpsd_pkg::fpsd_res_t next_sin;
	fpsd_pkg::fpsd_res_t next_cos;
	logic                hit;
	logic                next_reduce;
	logic [15:0]         op_w;
	logic [15:0]         ext_w;

	assign op_w  = issue_in.opcode;
	assign ext_w = issue_in.ext;

	// extension word travels with the opcode in one issue
	always_comb begin
		hit = issue_valid_in && op_w[15:12] == fpsd_pkg::OP_LINE
			&& op_w[11:9] == cpid && op_w[8:6] == fpsd_pkg::GEN_TYPE
			&& !ext_w[15] && !ext_w[13];
	end

	always_comb begin
		next_dec = '0;
		next_dec.op = fpsd_pkg::OP_NONE;
		next_dec.ea = fpsd_pkg::EA_NONE;
		if (ext_w[6:3] == fpsd_pkg::SC_OPM) begin
			next_dec.op = fpsd_pkg::OP_SINCOS;
		end else if (ext_w[6:0] == fpsd_pkg::SINH_OPM) begin
			next_dec.op = fpsd_pkg::OP_SINH;
		end else if (ext_w[6:0] == fpsd_pkg::SIN_OPM) begin
			next_dec.op = fpsd_pkg::OP_SIN;
		end
		next_dec.rm       = ext_w[14];
		next_dec.sin_dest = ext_w[9:7];
		next_dec.cos_dest = ext_w[2:0];
		next_dec.ea_reg   = op_w[2:0];
		if (!ext_w[14]) begin
			// effective address field ignored here
			next_dec.src_reg = ext_w[12:10];
			next_dec.fmt     = fpsd_pkg::FMT_S;
		end else begin
			next_dec.fmt = ext_w[12:10];
			if (ext_w[12:10] == fpsd_pkg::FMT_BAD) begin
				next_dec.illegal = 1'b1;
			end
			unique case (op_w[5:3])
				fpsd_pkg::M_DREG: begin
					next_dec.ea = fpsd_pkg::EA_DREG;
					if (!(ext_w[12:10] == fpsd_pkg::FMT_B
						|| ext_w[12:10] == fpsd_pkg::FMT_W
						|| ext_w[12:10] == fpsd_pkg::FMT_L
						|| ext_w[12:10] == fpsd_pkg::FMT_S)) begin
						next_dec.illegal = 1'b1;
					end
				end
				fpsd_pkg::M_AREG: next_dec.illegal = 1'b1;
				fpsd_pkg::M_IND:  next_dec.ea = fpsd_pkg::EA_IND;
				fpsd_pkg::M_POST: next_dec.ea = fpsd_pkg::EA_POST;
				fpsd_pkg::M_PRE:  next_dec.ea = fpsd_pkg::EA_PRE;
				fpsd_pkg::M_D16:  next_dec.ea = fpsd_pkg::EA_D16;
				fpsd_pkg::M_IDX:  next_dec.ea = fpsd_pkg::EA_IDX;
				fpsd_pkg::M_EXT: begin
					unique case (op_w[2:0])
						fpsd_pkg::R_ABSW: next_dec.ea = fpsd_pkg::EA_ABSW;
						fpsd_pkg::R_ABSL: next_dec.ea = fpsd_pkg::EA_ABSL;
						fpsd_pkg::R_PCD:  next_dec.ea = fpsd_pkg::EA_PCD;
						fpsd_pkg::R_PCX:  next_dec.ea = fpsd_pkg::EA_PCX;
						fpsd_pkg::R_IMM:  next_dec.ea = fpsd_pkg::EA_IMM;
						default:          next_dec.illegal = 1'b1;
					endcase
				end
			endcase
		end
		// an illegal source performs nothing
		if (!next_dec.illegal && next_dec.op != fpsd_pkg::OP_NONE) begin
			next_dec.wr_sin = 1'b1;
			next_dec.wr_cos = next_dec.op == fpsd_pkg::OP_SINCOS
				&& ext_w[2:0] != ext_w[9:7];
		end
		// operand latched before any result lands
		next_dec.read_first = !ext_w[14] && next_dec.wr_sin
			&& (ext_w[12:10] == ext_w[9:7]
			|| (next_dec.op == fpsd_pkg::OP_SINCOS
			&& ext_w[12:10] == ext_w[2:0]));
	end

	always_comb begin
		next_sin    = fpsd_pkg::RS_CALC;
		next_cos    = fpsd_pkg::RS_CALC;
		next_reduce = 1'b0;
		next_exc    = '0;
		next_exc.signalling_nan_flag = class_in.signalling_nan;
		next_exc.inexact_result_flag = class_in.inexact;
		next_exc.decimal_input_inexact_flag = next_dec.rm
			&& next_dec.fmt == fpsd_pkg::FMT_P && class_in.dec_inexact;
		if (next_dec.op == fpsd_pkg::OP_SINH) begin
			next_exc.overflow_flag  = class_in.overflow;
			next_exc.underflow_flag = class_in.underflow;
			if (class_in.zero) begin
				next_sin = fpsd_pkg::RS_ZERO;
			end else if (class_in.inf) begin
				next_sin = fpsd_pkg::RS_INF;
			end
		end else begin
			next_exc.operand_error_flag = class_in.inf;
			next_exc.underflow_flag     = class_in.sin_underflow;
			next_reduce    = class_in.beyond_2pi && !class_in.inf;
			if (class_in.inf) begin
				next_sin = fpsd_pkg::RS_NAN;
				next_cos = fpsd_pkg::RS_NAN;
			end else if (class_in.zero) begin
				next_sin = fpsd_pkg::RS_ZERO;
				next_cos = fpsd_pkg::RS_ONE;
			end else if (class_in.sin_underflow) begin
				next_cos = fpsd_pkg::RS_ONE;
			end
		end
	end

	// decode results, one cycle after issue
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			dec_valid_out <= 1'b0;
			dec_out       <= '0;
			sin_res_out   <= fpsd_pkg::RS_CALC;
			cos_res_out   <= fpsd_pkg::RS_CALC;
			reduce_out    <= 1'b0;
			cc_sine_out   <= 1'b0;
		end else begin
			dec_valid_out <= hit;
			if (hit) begin
				dec_out     <= next_dec;
				sin_res_out <= next_sin;
				cos_res_out <= next_cos;
				reduce_out  <= next_reduce;
				cc_sine_out <= next_dec.op == fpsd_pkg::OP_SINCOS;
			end
		end
	end

	// exception byte, rewritten by each performed operation
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			exc_out <= '0;
		end else if (hit && next_dec.wr_sin) begin
			exc_out <= next_exc;
		end else if (wr_in && addr_in == fpsd_pkg::REG_STAT) begin
			exc_out <= wdata_in[7:0];
		end
	end

	// quotient byte: software only
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			quot <= '0;
		end else if (wr_in && addr_in == fpsd_pkg::REG_STAT) begin
			quot <= wdata_in[15:8];
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cpid <= fpsd_pkg::CPID_RST;
		end else if (wr_in && addr_in == fpsd_pkg::REG_CTRL) begin
			cpid <= wdata_in[2:0];
		end
	end

	// read data the cycle after the strobe, zero otherwise
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_out <= '0;
		end else if (rd_in) begin
			unique case (addr_in)
				fpsd_pkg::REG_CTRL: rdata_out <= {29'h0, cpid};
				fpsd_pkg::REG_STAT: rdata_out <= {16'h0, quot, exc_out};
				fpsd_pkg::REG_LAST: rdata_out <= {6'h00, dec_out};
				default:            rdata_out <= '0;
			endcase
		end else begin
			rdata_out <= '0;
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);

	property p_line;
		issue_valid_in && (op_w[15:12] != fpsd_pkg::OP_LINE || op_w[11:9] != cpid)
		|=> !dec_valid_out;
	endproperty
	a_line: assert property (p_line) else $error("foreign line decoded");

	property p_areg;
		hit && ext_w[14] && op_w[5:3] == fpsd_pkg::M_AREG
		|=> dec_out.illegal && !dec_out.wr_sin;
	endproperty
	a_areg: assert property (p_areg) else $error("address reg source kept");

	property p_dreg;
		hit && ext_w[14] && op_w[5:3] == fpsd_pkg::M_DREG
		&& ext_w[12:10] == fpsd_pkg::FMT_P |=> dec_out.illegal;
	endproperty
	a_dreg: assert property (p_dreg) else $error("data reg packed accepted");

	property p_same;
		dec_valid_out && dec_out.sin_dest == dec_out.cos_dest |-> !dec_out.wr_cos;
	endproperty
	a_same: assert property (p_same) else $error("cosine kept on shared reg");

	property p_zero;
		hit && next_dec.op == fpsd_pkg::OP_SINCOS && class_in.zero && !class_in.inf
		|=> sin_res_out == fpsd_pkg::RS_ZERO && cos_res_out == fpsd_pkg::RS_ONE;
	endproperty
	a_zero: assert property (p_zero) else $error("zero source results wrong");

	property p_op_error;
		hit && next_dec.wr_sin && next_dec.op != fpsd_pkg::OP_SINH
		|=> exc_out.operand_error_flag == $past(class_in.inf);
	endproperty
	a_op_error: assert property (p_op_error) else $error("operand error wrong");

	property p_sin_under;
		hit && next_dec.wr_sin && next_dec.op == fpsd_pkg::OP_SINCOS
		&& class_in.sin_underflow && !class_in.inf && !class_in.zero
		|=> cos_res_out == fpsd_pkg::RS_ONE && exc_out.underflow_flag;
	endproperty
	a_sin_under: assert property (p_sin_under) else $error("underflow cosine not one");

	property p_clear;
		hit && next_dec.wr_sin && next_dec.op == fpsd_pkg::OP_SINCOS && !wr_in
		|=> !exc_out.overflow_flag && !exc_out.divide_zero_flag
		&& !exc_out.branch_unordered_flag && $stable(quot);
	endproperty
	a_clear: assert property (p_clear) else $error("sincos flags not cleared");

	property p_dec_inexact;
		hit && next_dec.wr_sin && next_dec.fmt != fpsd_pkg::FMT_P
		|=> !exc_out.decimal_input_inexact_flag;
	endproperty
	a_dec_inexact: assert property (p_dec_inexact) else $error("decimal inexact set");

	property p_cc;
		hit |=> cc_sine_out == ($past(ext_w[6:3]) == fpsd_pkg::SC_OPM);
	endproperty
	a_cc: assert property (p_cc) else $error("condition source wrong");

	property p_sinh;
		hit && next_dec.wr_sin && next_dec.op == fpsd_pkg::OP_SINH && class_in.inf
		|=> sin_res_out == fpsd_pkg::RS_INF && !exc_out.operand_error_flag
		&& !exc_out.divide_zero_flag;
	endproperty
	a_sinh: assert property (p_sinh) else $error("sinh infinity wrong");

	c_sincos: cover property (dec_valid_out && dec_out.op == fpsd_pkg::OP_SINCOS
		&& dec_out.wr_cos);
	c_overlap: cover property (dec_valid_out && dec_out.read_first);
	c_illegal: cover property (dec_valid_out && dec_out.illegal);
	c_sinh: cover property (dec_valid_out && dec_out.op == fpsd_pkg::OP_SINH);
endmodule // fpsd_core
`default_nettype wire

// >>> bench/fpsd_host.sv
// fpsd_host: issuing core model, builds opcode and extension words on request.
// assumes: bench sets the fields one and a half cycles before go_in is taken.
`timescale 1ns/100ps
`default_nettype none
module fpsd_host (
	// clock and reset
	input  wire logic                  mclk_in,
	input  wire logic                  resetn_in,
	// request fields
	input  wire logic                  go_in,
	input  wire logic [2:0]            cpid_in,
	input  wire logic [19:0]           fld_in,
	input  wire fpsd_pkg::fpsd_class_t cls_in,
	// issue toward the decoder
	output logic                       issue_valid_out,
	output var fpsd_pkg::fpsd_issue_t  issue_out,
	output var fpsd_pkg::fpsd_class_t  class_out
);
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			issue_valid_out <= 1'b0;
			issue_out <= '0;
			class_out <= '0;
		end else begin
			issue_valid_out <= go_in;
			if (go_in) begin
				// effective address zeroed in register mode
				issue_out.opcode <= {fpsd_pkg::OP_LINE, cpid_in, 3'h0,
					fld_in[19] ? fld_in[5:0] : 6'h00};
				issue_out.ext <= {1'b0, fld_in[19], 1'b0, fld_in[18:6]};
				class_out <= cls_in;
			end else begin
				// idle words do not keep the last value
				issue_out <= ~issue_out;
				class_out <= ~class_out;
			end
		end
	end
endmodule // fpsd_host
`default_nettype wire

// >>> bench/fpsd_core_tb.sv
// fpsd_core_tb: corner and random issues, register port reads and writes.
// assumes: fpsd_host drives issues; expectations are computed here.
`timescale 1ns/100ps
`default_nettype none
module fpsd_core_tb;
	logic                  mclk_in = 1'b0, resetn_in = 1'b0, go = 1'b0, wr = 1'b0, rd = 1'b0;
	logic                  rm, iv, dv, red, ccs;
	logic [2:0]            cpid = 3'h1, spec, dst, mode, rg;
	logic [6:0]            opm;
	logic [7:0]            addr = 8'h00, q = 8'h00;
	logic [19:0]           f = 20'h0_0000;
	logic [31:0]           wdata = 32'h0000_0000, rdata;
	int                    n_fail = 0, num_checks = 0;
	fpsd_pkg::fpsd_exc_t   ex = '0, exc;
	fpsd_pkg::fpsd_class_t cls = '0, cl;
	fpsd_pkg::fpsd_issue_t iss;
	fpsd_pkg::fpsd_dec_t   d;
	fpsd_pkg::fpsd_res_t   sr, cr;
	logic [19:0]           corner [9] = '{{1'b0, 3'h2, 3'h2, 7'h32, 6'h00},
		{1'b0, 3'h5, 3'h1, 7'h35, 6'h00}, {1'b0, 3'h3, 3'h3, 7'h02, 6'h00},
		{1'b1, 3'h3, 3'h4, 7'h30, 6'h3c}, {1'b1, 3'h4, 3'h6, 7'h0e, 6'h02},
		{1'b1, 3'h2, 3'h0, 7'h31, 6'h01}, {1'b1, 3'h0, 3'h1, 7'h02, 6'h0b},
		{1'b1, 3'h1, 3'h2, 7'h0e, 6'h3d}, {1'b0, 3'h1, 3'h1, 7'h7f, 6'h00}};
	assign {rm, spec, dst, opm, mode, rg} = f;
	initial forever #4 mclk_in = ~mclk_in;
	fpsd_host i_host (.mclk_in(mclk_in), .resetn_in(resetn_in), .go_in(go), .cpid_in(cpid),
		.fld_in(f), .cls_in(cls), .issue_valid_out(iv), .issue_out(iss), .class_out(cl));
	fpsd_core i_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .issue_valid_in(iv),
		.issue_in(iss), .class_in(cl), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
		.rd_in(rd), .rdata_out(rdata), .dec_valid_out(dv), .dec_out(d), .sin_res_out(sr),
		.cos_res_out(cr), .reduce_out(red), .cc_sine_out(ccs), .exc_out(exc));
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (e !== g) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic reg_wr(logic [7:0] a, logic [31:0] v);
		@(posedge mclk_in);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge mclk_in);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(logic [7:0] a, logic [31:0] e);
		@(posedge mclk_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk_in);
		rd <= 1'b0;
		@(negedge mclk_in);
		chk("rdata", e, rdata);
	endtask
	task automatic check_op();
		logic [1:0] op;
		logic ill, ws, wc, sh, i1, rf;
		logic [3:0] ea;
		op = opm[6:3] == 4'h6 ? 2'h1 : opm == 7'h02 ? 2'h3 : opm == 7'h0e ? 2'h2 : 2'h0;
		ill = rm && (mode == 3'h1 || spec == 3'h7 || (mode == 3'h7 && rg > 3'h4) ||
			(mode == 3'h0 && !(spec inside {3'h0, 3'h1, 3'h4, 3'h6})));
		ws = op != 2'h0 && !ill;
		wc = ws && op == 2'h1 && opm[2:0] != dst;
		sh = op == 2'h3;
		i1 = rm && spec == 3'h3 && cls.dec_inexact;
		rf = !rm && (ws && spec == dst || wc && spec == opm[2:0]);
		ea = rm ? (mode == 3'h0 ? 4'h1 : mode < 3'h7 ? {1'b0, mode} : 4'h7 + rg) : 4'h0;
		chk("op", op, d.op);
		chk("illegal", ill, d.illegal);
		chk("wr_sin", ws, d.wr_sin);
		chk("wr_cos", wc, d.wr_cos);
		chk("read_first", rf, d.read_first);
		if (ws) begin
			ex = sh ? {1'b0, cls.signalling_nan, 1'b0, cls.overflow, cls.underflow, 1'b0,
				cls.inexact, i1} : {1'b0, cls.signalling_nan, cls.inf, 1'b0,
				cls.sin_underflow, 1'b0, cls.inexact, i1};
			chk("sin_res", cls.inf ? (sh ? 3'h4 : 3'h3) : {2'h0, cls.zero}, sr);
			if (op == 2'h1) begin
				chk("cos_res", cls.inf ? 3'h3 : {cls.zero | cls.sin_underflow, 1'b0}, cr);
				chk("cos_dest", opm[2:0], d.cos_dest);
			end
			chk("reduce", !sh && cls.beyond_2pi && !cls.inf, red);
			chk("cc_sine", op == 2'h1, ccs);
			chk("sin_dest", dst, d.sin_dest);
			chk("spec", spec, rm ? d.fmt : d.src_reg);
			chk("ea", ea, d.ea);
			if (rm) chk("ea_reg", rg, d.ea_reg);
		end
		chk("exc", ex, exc);
	endtask
	task automatic send(logic [19:0] v, logic p);
		int n;
		@(negedge mclk_in);
		f = v;
		cls = fpsd_pkg::fpsd_class_t'(9'($urandom));
		if (cls.zero) cls.inf = 1'b0;
		@(posedge mclk_in);
		go <= 1'b1;
		@(posedge mclk_in);
		go <= 1'b0;
		n = 0;
		do begin
			@(negedge mclk_in);
			n++;
		end while (dv !== 1'b1 && n < 4);
		chk("dec_valid", p, dv);
		if (p) check_op();
	endtask
	initial begin
		logic [6:0] k;
		void'($urandom(67900));
		repeat (6) @(posedge mclk_in);
		resetn_in <= 1'b1;
		reg_rd(8'h00, 32'h0000_0001);
		reg_rd(8'h04, 32'h0000_0000);
		reg_rd(8'h0c, 32'h0000_0000);
		reg_wr(8'h04, 32'h0000_a5ff);
		q = 8'ha5;
		ex = 8'hff;
		foreach (corner[i]) send(corner[i], 1'b1);
		for (int i = 0; i < 200; i++) begin
			k = $urandom % 3 == 0 ? 7'h02 : $urandom % 2 ? 7'h0e : {4'h6, 3'($urandom)};
			send({1'($urandom), 3'($urandom), 3'($urandom), k, 6'($urandom)}, 1'b1);
			if (i % 16 == 0) reg_rd(8'h04, {16'h0000, q, ex});
		end
		cpid = 3'h3;
		send(20'h0_0080, 1'b0);
		reg_wr(8'h00, 32'h0000_0003);
		send(20'h0_0080, 1'b1);
		reg_rd(8'h00, 32'h0000_0003);
		reg_rd(8'h08, 32'h0301_0015);
		test_done();
	end
	initial begin
		repeat (20000) @(posedge mclk_in);
		n_fail++;
		test_done();
	end
endmodule // fpsd_core_tb
`default_nettype wire
